// ==== epf_params.svh ====
/*
  Constants for the encoder position feedback block: register offsets,
  reset values, field positions and timing counts.
  Assumes a 40 MHz system clock.
*/
`ifndef EPF_PARAMS_SVH
`define EPF_PARAMS_SVH

`define EPF_CLK_HZ          40000000
`define EPF_SPD_WIN_MS      10
`define EPF_SPD_WIN_CYC     ((`EPF_CLK_HZ / 1000) * `EPF_SPD_WIN_MS)
`define EPF_SPD_PER_SEC     (1000 / `EPF_SPD_WIN_MS)
`define EPF_DEG_FULL        32'd3600000
`define EPF_TURN_BITS       12
`define EPF_ALIGN_TRIES     4'h3
`define EPF_ALIGN_WAIT_CYC  24'd40000
`define EPF_STILL_CYC       24'd400000

`define EPF_A_CTRL          12'h000
`define EPF_A_LINES         12'h004
`define EPF_A_OFFSET        12'h008
`define EPF_A_GEAR_IN       12'h00c
`define EPF_A_GEAR_OUT      12'h010
`define EPF_A_STATUS        12'h014
`define EPF_A_IRQ_STAT      12'h018
`define EPF_A_IRQ_MASK      12'h01c
`define EPF_A_TALLY         12'h020
`define EPF_A_TURNS         12'h024
`define EPF_A_SPEED_RPM     12'h028
`define EPF_A_SHAFT_ANG     12'h02c
`define EPF_A_LOAD_ANG      12'h030
`define EPF_A_SPEED_HZ      12'h034

`define EPF_C_INVERT        0
`define EPF_C_TALLY_CLR     1
`define EPF_C_RETRY         2
`define EPF_C_ENC_TYPE      4

`define EPF_RST_LINES       32'd2048
`define EPF_RST_GEAR        32'd1

`endif

// ==== epf_pkg.sv ====
/*
  Types for the encoder position feedback block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package epf_pkg;

  typedef enum logic [3:0] {
    EPF_ST_NOT_REQ   = 4'h0,
    EPF_ST_DRIVE_RUN = 4'h1,
    EPF_ST_MOTOR_RUN = 4'h2,
    EPF_ST_ENC_FAULT = 4'h3,
    EPF_ST_IN_PROG   = 4'h4,
    EPF_ST_ID_POS    = 4'h5,
    EPF_ST_DONE      = 4'h6,
    EPF_ST_LOST      = 4'h7,
    EPF_ST_FAILED    = 4'h8,
    EPF_ST_WARN      = 4'h9
  } epf_align_code_t;

  typedef enum logic [1:0] {
    EPF_ENC_INCR   = 2'h0,
    EPF_ENC_ABS_ST = 2'h1,
    EPF_ENC_ABS_MT = 2'h2
  } epf_enc_type_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [11:0] turns;
    logic [31:0] angle;
  } epf_abs_pos_t;

  typedef struct packed {
    logic        phase_a;
    logic        phase_b;
  } epf_quad_t;

endpackage

// ==== epf_encoder_feedback.sv ====
/*
  Encoder position feedback: quadrature decode, edge tally, speed,
  turn counter, shaft and load angle, absolute alignment, APB slave.
  Assumes encoder phases and absolute word are synchronous to I_CLK_SYS.
  Angles are in units of 0.0001 degree (3600000 per turn).
*/
// The address map and the APB interface to the registers are this design's own decisions.
`include "epf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module epf_encoder_feedback
  import epf_pkg::*;
#(
  parameter int unsigned SPD_WIN_CYC = `EPF_SPD_WIN_CYC
)
(
  input  wire logic         I_CLK_SYS,
  input  wire logic         I_RST_N,
  input  wire epf_quad_t    I_QUAD,
  input  wire epf_abs_pos_t I_ABS_POS,
  input  wire logic         I_DRIVE_RUN,
  input  wire logic         I_PSEL,
  input  wire logic         I_PENABLE,
  input  wire logic         I_PWRITE,
  input  wire logic [11:0]  I_PADDR,
  input  wire logic [31:0]  I_PWDATA,
  output logic [31:0]       O_PRDATA,
  output logic              O_PREADY,
  output logic              O_PSLVERR,
  output logic              O_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus decode
  logic [31:0] ctrl_q, lines_q, offset_q, gear_in_q, gear_out_q;
  logic [3:0]  irq_stat_q, irq_mask_q, irq_ev;
  logic [31:0] tally_q, turns_q, rpm_q, hz_q, shaft_q, load_q;
  logic [31:0] rdata_d;
  logic        wr, rd, hit;
  logic        invert, tally_clr, retry;
  epf_enc_type_t enc_type;
  epf_align_code_t state_q;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= `EPF_A_SPEED_HZ);
  endfunction

  assign wr        = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd        = I_PSEL && I_PENABLE && !I_PWRITE;
  assign hit       = addr_hit(I_PADDR);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;
  assign invert    = ctrl_q[`EPF_C_INVERT];
  assign tally_clr = ctrl_q[`EPF_C_TALLY_CLR];
  assign retry     = ctrl_q[`EPF_C_RETRY];
  assign enc_type  = epf_enc_type_t'(ctrl_q[`EPF_C_ENC_TYPE +: 2]);

  logic cfg_chg, align_done;
  assign cfg_chg = wr && hit && ((I_PADDR == `EPF_A_OFFSET)
                   || (I_PADDR == `EPF_A_CTRL
                       && I_PWDATA[`EPF_C_ENC_TYPE +: 2]
                          != ctrl_q[`EPF_C_ENC_TYPE +: 2]));

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ctrl_q     <= 32'h0;
      lines_q    <= `EPF_RST_LINES;
      offset_q   <= 32'h0;
      gear_in_q  <= `EPF_RST_GEAR;
      gear_out_q <= `EPF_RST_GEAR;
      irq_mask_q <= 4'h0;
    end
    else
    begin
      if (wr && I_PADDR == `EPF_A_CTRL)
        ctrl_q <= {26'h0, I_PWDATA[5:0]};
      else if (align_done)
        ctrl_q[`EPF_C_RETRY] <= 1'b0;
      if (wr && I_PADDR == `EPF_A_LINES && I_PWDATA != 32'h0)
        lines_q <= I_PWDATA;
      if (wr && I_PADDR == `EPF_A_OFFSET && I_PWDATA < `EPF_DEG_FULL)
        offset_q <= I_PWDATA;
      if (wr && I_PADDR == `EPF_A_GEAR_IN && I_PWDATA != 32'h0)
        gear_in_q <= I_PWDATA;
      if (wr && I_PADDR == `EPF_A_GEAR_OUT)
        gear_out_q <= I_PWDATA;
      if (wr && I_PADDR == `EPF_A_IRQ_MASK)
        irq_mask_q <= I_PWDATA[3:0];
    end
  end

  always_comb
  begin
    case (I_PADDR)
      `EPF_A_CTRL:      rdata_d = ctrl_q;
      `EPF_A_LINES:     rdata_d = lines_q;
      `EPF_A_OFFSET:    rdata_d = offset_q;
      `EPF_A_GEAR_IN:   rdata_d = gear_in_q;
      `EPF_A_GEAR_OUT:  rdata_d = gear_out_q;
      `EPF_A_STATUS:    rdata_d = {28'h0, state_q};
      `EPF_A_IRQ_STAT:  rdata_d = {28'h0, irq_stat_q};
      `EPF_A_IRQ_MASK:  rdata_d = {28'h0, irq_mask_q};
      `EPF_A_TALLY:     rdata_d = tally_q;
      `EPF_A_TURNS:     rdata_d = turns_q;
      `EPF_A_SPEED_RPM: rdata_d = rpm_q;
      `EPF_A_SHAFT_ANG: rdata_d = shaft_q;
      `EPF_A_LOAD_ANG:  rdata_d = load_q;
      `EPF_A_SPEED_HZ:  rdata_d = hz_q;
      default:          rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_PRDATA <= 32'h0;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
      O_PRDATA <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Quadrature decode and edge tally
  epf_quad_t q_prev_q;
  logic      step, dir_up, raw_up;
  logic [1:0] g_now, g_old;

  assign g_now = {I_QUAD.phase_a, I_QUAD.phase_a ^ I_QUAD.phase_b};
  assign g_old = {q_prev_q.phase_a, q_prev_q.phase_a ^ q_prev_q.phase_b};
  assign step   = (g_now != g_old)
                  && (2'(g_now - g_old) != 2'h2);
  assign raw_up = (g_now - g_old) == 2'h1;
  assign dir_up = raw_up ^ invert;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      q_prev_q <= '0;
      tally_q  <= 32'h0;
    end
    else
    begin
      q_prev_q <= I_QUAD;
      if (tally_clr)
        tally_q <= 32'h0;
      else if (step)
        tally_q <= dir_up ? tally_q + 32'h1 : tally_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position within turn and turn counter
  logic [31:0] pos_q, lines4;
  logic        wrap_up, wrap_dn, sat_hi, sat_lo, preload;
  logic [31:0] turns_base;
  assign lines4  = {lines_q[29:0], 2'b00};
  assign wrap_up = step && dir_up && (pos_q == lines4 - 32'h1);
  assign wrap_dn = step && !dir_up && (pos_q == 32'h0);
  assign sat_hi  = (turns_q == 32'h7fffffff);
  assign sat_lo  = (turns_q == 32'h80000000);
  assign preload = (enc_type == EPF_ENC_ABS_MT) && I_ABS_POS.valid
                   && (state_q == EPF_ST_ID_POS);
  assign turns_base = (turns_q[11:0] == 12'hfff && I_ABS_POS.turns == 12'h0)
                    ? turns_q + 32'h1 : turns_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pos_q   <= 32'h0;
      turns_q <= 32'h0;
    end
    else
    begin
      if (wrap_up)
        pos_q <= 32'h0;
      else if (wrap_dn)
        pos_q <= lines4 - 32'h1;
      else if (step)
        pos_q <= dir_up ? pos_q + 32'h1 : pos_q - 32'h1;
      if (preload)
        turns_q <= {turns_base[31:12], I_ABS_POS.turns};
      else if (wrap_up && !sat_hi)
        turns_q <= turns_q + 32'h1;
      else if (wrap_dn && !sat_lo)
        turns_q <= turns_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Speed over a fixed window
  logic [31:0] win_cnt_q, win_edges_q;
  logic [31:0] eps;
  logic [63:0] rpm_wide;
  logic        win_end;
  assign win_end  = (win_cnt_q == SPD_WIN_CYC - 1);
  assign eps      = win_edges_q * `EPF_SPD_PER_SEC;
  assign rpm_wide = {{32{eps[31]}}, eps} * 64'd60;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      win_cnt_q   <= 32'h0;
      win_edges_q <= 32'h0;
      hz_q        <= 32'h0;
      rpm_q       <= 32'h0;
    end
    else
    begin
      win_cnt_q <= win_end ? 32'h0 : win_cnt_q + 32'h1;
      if (win_end)
      begin
        win_edges_q <= step ? (dir_up ? 32'h1 : 32'hffffffff) : 32'h0;
        hz_q  <= $signed(eps) / $signed(lines4);
        rpm_q <= 32'($signed(rpm_wide) / $signed({32'h0, lines4}));
      end
      else if (step)
        win_edges_q <= dir_up ? win_edges_q + 32'h1 : win_edges_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shaft and load angles
  logic [31:0] inc_ang, abs_ang_q, raw_ang, zero_ang;
  logic [63:0] load_wide;
  assign inc_ang  = 32'(({32'h0, pos_q} * 64'd3600000) / {32'h0, lines4});
  assign raw_ang  = (state_q == EPF_ST_DONE)
                    ? ((abs_ang_q + inc_ang) % `EPF_DEG_FULL) : inc_ang;
  assign zero_ang = (enc_type != EPF_ENC_INCR)
                    ? ((raw_ang + `EPF_DEG_FULL - offset_q)
                       % `EPF_DEG_FULL) : raw_ang;
  assign load_wide = $signed({32'h0, zero_ang}) * $signed({{32{gear_out_q[31]}},
                     gear_out_q});

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      shaft_q <= 32'h0;
      load_q  <= 32'h0;
    end
    else
    begin
      shaft_q <= zero_ang;
      load_q  <= 32'($signed(load_wide)
                 / $signed({32'h0, gear_in_q}));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Absolute alignment state machine
  logic [3:0]  tries_q;
  logic [23:0] wait_q, still_q;
  logic        moving, start;
  assign moving     = (still_q != `EPF_STILL_CYC);
  assign start      = cfg_chg || (retry && state_q == EPF_ST_FAILED);
  assign align_done = retry && (state_q == EPF_ST_DONE);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      still_q <= 24'h0;
    else if (step)
      still_q <= 24'h0;
    else if (moving)
      still_q <= still_q + 24'h1;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_q   <= EPF_ST_IN_PROG;
      tries_q   <= 4'h0;
      wait_q    <= 24'h0;
      abs_ang_q <= 32'h0;
    end
    else if (enc_type == EPF_ENC_INCR)
      state_q <= EPF_ST_NOT_REQ;
    else if (start || state_q == EPF_ST_NOT_REQ)
    begin
      state_q <= EPF_ST_IN_PROG;
      tries_q <= 4'h0;
      wait_q  <= 24'h0;
    end
    else
    begin
      case (state_q)
        EPF_ST_IN_PROG, EPF_ST_DRIVE_RUN, EPF_ST_MOTOR_RUN,
        EPF_ST_ENC_FAULT:
          if (I_DRIVE_RUN)
            state_q <= EPF_ST_DRIVE_RUN;
          else if (moving)
            state_q <= EPF_ST_MOTOR_RUN;
          else if (I_ABS_POS.fault)
            state_q <= EPF_ST_ENC_FAULT;
          else
          begin
            state_q <= EPF_ST_ID_POS;
            wait_q  <= 24'h0;
          end
        EPF_ST_ID_POS:
          if (I_ABS_POS.valid && !I_ABS_POS.fault)
          begin
            abs_ang_q <= (I_ABS_POS.angle + `EPF_DEG_FULL - inc_ang) % `EPF_DEG_FULL;
            state_q   <= EPF_ST_DONE;
          end
          else if (wait_q == `EPF_ALIGN_WAIT_CYC)
          begin
            tries_q <= tries_q + 4'h1;
            wait_q  <= 24'h0;
            state_q <= (tries_q + 4'h1 == `EPF_ALIGN_TRIES)
                       ? EPF_ST_FAILED : EPF_ST_IN_PROG;
          end
          else
            wait_q <= wait_q + 24'h1;
        EPF_ST_DONE:
          if (I_ABS_POS.fault)
            state_q <= EPF_ST_LOST;
        EPF_ST_LOST, EPF_ST_FAILED, EPF_ST_WARN:
          state_q <= state_q;
        default:
          state_q <= EPF_ST_IN_PROG;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: 0 done, 1 failed, 2 lost, 3 turn wrap
  assign irq_ev = {wrap_up || wrap_dn,
                   state_q != EPF_ST_LOST && state_q == EPF_ST_DONE
                     && I_ABS_POS.fault,
                   state_q == EPF_ST_ID_POS && wait_q == `EPF_ALIGN_WAIT_CYC
                     && tries_q + 4'h1 == `EPF_ALIGN_TRIES,
                   state_q == EPF_ST_ID_POS && I_ABS_POS.valid
                     && !I_ABS_POS.fault};

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      irq_stat_q <= 4'h0;
    else if (rd && I_PADDR == `EPF_A_IRQ_STAT)
      irq_stat_q <= irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(irq_stat_q & irq_mask_q);
  end

endmodule

`default_nettype wire

// ==== epf_encoder_feedback_sva.sv ====
/* Port checker for epf_encoder_feedback, bound at the file foot.
   Assumes zero-wait APB and phases synchronous to I_CLK_SYS. */
`include "epf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module epf_fb_chk
  import epf_pkg::*;
#(
  parameter int unsigned SPD_WIN_CYC = `EPF_SPD_WIN_CYC
)
(
  input wire logic         I_CLK_SYS,
  input wire logic         I_RST_N,
  input wire epf_quad_t    I_QUAD,
  input wire epf_abs_pos_t I_ABS_POS,
  input wire logic         I_DRIVE_RUN,
  input wire logic         I_PSEL,
  input wire logic         I_PENABLE,
  input wire logic         I_PWRITE,
  input wire logic [11:0]  I_PADDR,
  input wire logic [31:0]  I_PWDATA,
  input wire logic [31:0]  O_PRDATA,
  input wire logic         O_PREADY,
  input wire logic         O_PSLVERR,
  input wire logic         O_IRQ
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);
  //////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [31:0] mask_q;
  logic [31:0] last_q;
  logic [3:0]  still_q;
  logic        ok_q;
  epf_quad_t   quad_q;
  wire         wr = I_PSEL && I_PENABLE && I_PWRITE;
  wire         wr_c = wr && I_PADDR == `EPF_A_CTRL;
  wire         rd_t = I_PSEL && I_PENABLE && !I_PWRITE &&
                      I_PADDR == `EPF_A_TALLY;
  wire         moved = I_QUAD != quad_q;
  // Shadow of control and mask writes
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    if (!I_RST_N)
    begin
      ctrl_q <= 32'h0;
      mask_q <= 32'h0;
    end
    else if (wr_c)
      ctrl_q <= I_PWDATA;
    else if (wr && I_PADDR == `EPF_A_IRQ_MASK)
      mask_q <= I_PWDATA;
  // Quiet cycles since last phase change
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    if (!I_RST_N)
    begin
      quad_q  <= '0;
      still_q <= 4'h0;
    end
    else
    begin
      quad_q  <= I_QUAD;
      still_q <= moved ? 4'h0 : still_q + {3'h0, still_q != 4'hf};
    end
  // Last tally read while the shaft stood still
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    if (!I_RST_N)
    begin
      ok_q   <= 1'b0;
      last_q <= 32'h0;
    end
    else if (moved || wr_c)
      ok_q <= 1'b0;
    else if (rd_t)
    begin
      ok_q   <= still_q >= 4'h8;
      last_q <= O_PRDATA;
    end
  //////////////////////////////////////////////////////////////
  sequence s_rd(logic [11:0] a);
    I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == a ##1 I_PENABLE;
  endsequence
  property p_ready; I_PSEL |-> O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    I_PSEL && I_PENABLE && I_PADDR > 12'h034 |-> O_PSLVERR;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_code; s_rd(`EPF_A_STATUS) |-> O_PRDATA <= 32'h9; endproperty
  a_code: assert property (p_code) else $error("bad state code");
  property p_ofs; s_rd(`EPF_A_OFFSET) |-> O_PRDATA < `EPF_DEG_FULL;
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset range");
  property p_gear; s_rd(`EPF_A_GEAR_IN) |-> O_PRDATA != 32'h0;
  endproperty
  a_gear: assert property (p_gear) else $error("zero gear in");
  property p_clr;
    s_rd(`EPF_A_TALLY) ##0 ctrl_q[1] |-> O_PRDATA == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("tally not held");
  property p_hold;
    s_rd(`EPF_A_TALLY) ##0 (ok_q && still_q >= 4'h8 && !ctrl_q[1])
      |-> O_PRDATA == last_q;
  endproperty
  a_hold: assert property (p_hold) else $error("tally drift");
  property p_irq; O_IRQ |-> (mask_q | $past(mask_q)) != 32'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind epf_encoder_feedback epf_fb_chk #(.SPD_WIN_CYC(SPD_WIN_CYC)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_QUAD(I_QUAD),
  .I_ABS_POS(I_ABS_POS), .I_DRIVE_RUN(I_DRIVE_RUN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));
`default_nettype wire

// ==== epf_enc_model.sv ====
/* Shaft encoder model: quadrature phases and a periodic absolute word.
   Assumes one edge per i_step pulse, stepped by the bench. */
`include "epf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module epf_enc_model
  import epf_pkg::*;
#(
  parameter int LINES   = 25,
  parameter int ABS_GAP = 64
)
(
  input  wire logic    i_clk,
  input  wire logic    i_rst_n,
  input  wire logic    i_step,
  input  wire logic    i_fwd,
  output var epf_quad_t    o_quad,
  output var epf_abs_pos_t o_abs
);
  localparam int EDGES = 4 * LINES;
  int pos;
  int gap;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      pos <= 0;
    else if (i_step)
      pos <= i_fwd ? pos + 1 : pos - 1;
  // Gray order, phase b leads when turning forward (counts up)
  assign o_quad = {pos[1], pos[0] ^ pos[1]};
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      gap   <= 0;
      o_abs <= '0;
    end
    else
    begin
      gap         <= (gap == ABS_GAP - 1) ? 0 : gap + 1;
      o_abs.valid <= gap == 0;
      o_abs.fault <= 1'b0;
      o_abs.turns <= 12'(pos / EDGES);
      o_abs.angle <= 32'(pos % EDGES) * `EPF_DEG_FULL / 32'(EDGES);
    end
endmodule
`default_nettype wire

// ==== epf_encoder_feedback_tb.sv ====
/* Self-checking bench for epf_encoder_feedback with an APB master.
   Assumes the shaft model and the bound port checker. */
`include "epf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module epf_encoder_feedback_tb
  import epf_pkg::*;
;
  localparam int LINES = 25;
  localparam int HZ = (1000 / 10) * `EPF_SPD_PER_SEC / (4 * LINES);
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel = 1'b0;
  logic         pen = 1'b0;
  logic         pwr = 1'b0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0;
  logic         run = 1'b0;
  logic         step = 1'b0;
  logic         fwd = 1'b1;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic [31:0]  rd;
  logic         err;
  epf_quad_t    quad;
  epf_abs_pos_t abs_w;
  int           fails = 0;
  int           num_checks = 0;
  int           cyc = 0;
  int           m_pos;
  int           ang;
  logic [11:0]  ra [$] = '{`EPF_A_LINES, `EPF_A_GEAR_IN, `EPF_A_GEAR_OUT,
                          `EPF_A_TALLY, `EPF_A_TURNS, `EPF_A_STATUS};
  logic [31:0]  re [$] = '{`EPF_RST_LINES, `EPF_RST_GEAR, `EPF_RST_GEAR,
                          32'h0, 32'h0, 32'h0};
  always #12.5 clk = ~clk;
  epf_encoder_feedback #(.SPD_WIN_CYC(1000)) dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_QUAD(quad), .I_ABS_POS(abs_w),
    .I_DRIVE_RUN(run), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq));
  epf_enc_model #(.LINES(LINES)) u_enc (
    .i_clk(clk), .i_rst_n(rst_n), .i_step(step), .i_fwd(fwd),
    .o_quad(quad), .o_abs(abs_w));
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input logic [31:0] g);
    num_checks++;
    if ($isunknown(g) || $signed(g) < lo || $signed(g) > hi)
    begin
      fails++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, $signed(g));
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // One phase edge per step, per cycles apart
  task automatic move(input int k, input logic f, input int per);
    repeat (k)
    begin
      @(posedge clk);
      step <= 1'b1;
      fwd  <= f;
      @(posedge clk);
      step <= 1'b0;
      repeat (per - 2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'h556142be));
    foreach (ra[i])
      rc("reset", ra[i], re[i]);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("bad_read", 32'h0, rd);
    apb(1'b1, `EPF_A_LINES, 32'(LINES));
    m_pos = 1 + 32'($urandom_range(39));
    move(m_pos, 1'b1, 4);
    rc("tally", `EPF_A_TALLY, 32'(m_pos));
    move(250, 1'b1, 10);
    m_pos += 250;
    apb(1'b0, `EPF_A_SPEED_HZ, 32'h0);
    chk_rng("hz", HZ - 2, HZ + 2, rd);
    apb(1'b0, `EPF_A_SPEED_RPM, 32'h0);
    chk_rng("rpm", 60 * HZ - 120, 60 * HZ + 120, rd);
    rc("tally", `EPF_A_TALLY, 32'(m_pos));
    rc("turns", `EPF_A_TURNS, 32'(m_pos / (4 * LINES)));
    chk("irq_masked", 32'h0, {31'h0, irq});
    rc("irq_stat", `EPF_A_IRQ_STAT, 32'h8);
    rc("irq_clr", `EPF_A_IRQ_STAT, 32'h0);
    apb(1'b1, `EPF_A_IRQ_MASK, 32'h8);
    move(100, 1'b1, 2);
    m_pos += 100;
    chk("irq", 32'h1, {31'h0, irq});
    rc("irq_stat", `EPF_A_IRQ_STAT, 32'h8);
    repeat (2) @(posedge clk);
    chk("irq_low", 32'h0, {31'h0, irq});
    apb(1'b1, `EPF_A_CTRL, 32'h1);
    move(150, 1'b1, 10);
    m_pos -= 150;
    apb(1'b0, `EPF_A_SPEED_HZ, 32'h0);
    chk_rng("hz_inv", -HZ - 2, -HZ + 2, rd);
    apb(1'b0, `EPF_A_SPEED_RPM, 32'h0);
    chk_rng("rpm_inv", -60 * HZ - 120, -60 * HZ + 120, rd);
    rc("turns_inv", `EPF_A_TURNS, 32'(m_pos / (4 * LINES)));
    apb(1'b1, `EPF_A_CTRL, 32'h2);
    move(5, 1'b1, 4);
    rc("tally_clr", `EPF_A_TALLY, 32'h0);
    apb(1'b1, `EPF_A_CTRL, 32'h0);
    move(3, 1'b1, 4);
    rc("tally_rel", `EPF_A_TALLY, 32'h3);
    rc("tally_hold", `EPF_A_TALLY, 32'h3);
    apb(1'b1, `EPF_A_OFFSET, 32'h0036ee7f);
    rc("offset", `EPF_A_OFFSET, 32'h0036ee7f);
    apb(1'b1, `EPF_A_OFFSET, `EPF_DEG_FULL);
    rc("offset_max", `EPF_A_OFFSET, 32'h0036ee7f);
    apb(1'b1, `EPF_A_GEAR_IN, 32'h0);
    rc("gear_in", `EPF_A_GEAR_IN, `EPF_RST_GEAR);
    apb(1'b1, `EPF_A_GEAR_OUT, 32'h3);
    run <= 1'b1;
    apb(1'b1, `EPF_A_CTRL, 32'h10);
    repeat (20) @(posedge clk);
    rc("state_run", `EPF_A_STATUS, 32'h1);
    run <= 1'b0;
    move(4, 1'b1, 4);
    rc("state_move", `EPF_A_STATUS, 32'h2);
    m_pos += 12;
    ang = ((m_pos % (4 * LINES)) * (3600000 / (4 * LINES)) + 1) % 3600000;
    rc("shaft", `EPF_A_SHAFT_ANG, 32'(ang));
    rc("load", `EPF_A_LOAD_ANG, 32'(3 * ang));
    apb(1'b1, `EPF_A_CTRL, 32'h0);
    repeat (16) @(posedge clk);
    rc("state_none", `EPF_A_STATUS, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
